// file: core/tmv_pkg.sv
// Constants and types shared by the compare timer files
`default_nettype none
package tmv_pkg;
   localparam int          AW           = 18;
   localparam int          DW           = 32;
   localparam int          PRESC_W      = 7;
   // Register indexes; byte address is four times the index
   localparam logic [15:0] IDX_CTRL0    = 16'hFFB8;
   localparam logic [15:0] IDX_STATUS   = 16'hFFB9;
   localparam logic [15:0] IDX_CMP_A    = 16'hFFBA;
   localparam logic [15:0] IDX_CMP_B    = 16'hFFBB;
   localparam logic [15:0] IDX_COUNT    = 16'hFFBC;
   localparam logic [15:0] IDX_CTRL1    = 16'hFFBD;
   // Reset values
   localparam logic [7:0]  CTRL0_RST    = 8'h00;
   localparam logic [7:0]  CMP_RST      = 8'hFF;
   localparam logic [7:0]  COUNT_RST    = 8'h00;
   localparam logic [7:0]  COUNT_MAX    = 8'hFF;
   localparam logic [3:0]  OS_RST       = 4'h0;
   localparam logic [1:0]  EDGE_RST     = 2'h0;
   localparam logic [7:0]  STATUS_FIX   = 8'h10;
   localparam logic [7:0]  CTRL1_FIX    = 8'hE2;
   // Field positions
   localparam int          BIT_IRQ_B    = 7;
   localparam int          BIT_IRQ_A    = 6;
   localparam int          BIT_IRQ_W    = 5;
   localparam int          BIT_FLAG_B   = 7;
   localparam int          BIT_FLAG_A   = 6;
   localparam int          BIT_FLAG_W   = 5;
   localparam int          BIT_TRIGGER_GATE_EN     = 2;
   localparam int          BIT_ICKS     = 0;
   // Field encodings
   localparam logic [1:0]  CLR_NONE     = 2'h0;
   localparam logic [1:0]  CLR_A        = 2'h1;
   localparam logic [1:0]  CLR_B        = 2'h2;
   localparam logic [1:0]  CLR_EXT      = 2'h3;
   localparam logic [2:0]  CKS_EXT_RISE = 3'h5;
   localparam logic [2:0]  CKS_EXT_FALL = 3'h6;
   localparam logic [2:0]  CKS_EXT_BOTH = 3'h7;
   localparam logic [1:0]  OS_LOW       = 2'h1;
   localparam logic [1:0]  OS_HIGH      = 2'h2;
   localparam logic [1:0]  OS_TOG       = 2'h3;
   localparam logic [1:0]  EDGE_RISE    = 2'h1;
   localparam logic [1:0]  EDGE_FALL    = 2'h2;
   localparam logic [1:0]  EDGE_BOTH    = 2'h3;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   typedef enum logic [0:0] {
      TMV_RUN  = 1'b0,
      TMV_HALT = 1'b1
   } tmv_run_t;
endpackage : tmv_pkg
`default_nettype wire

// file: core/tmv_edge_if.sv
// Synchronised pin level with its edge pulses
`default_nettype none
interface tmv_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : tmv_edge_if
`default_nettype wire

// file: core/tmv_pin_sync.sv
// Two-stage pin synchroniser with edge detection
`default_nettype none
module tmv_pin_sync (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Pin and result
   input  wire logic pin,
   tmv_edge_if.src   edge_o
);
   logic meta;
   logic stable;
   logic prev;

   // Only the second stage and later feed edge logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta   <= 1'b0;
         stable <= 1'b0;
         prev   <= 1'b0;
      end else begin
         meta   <= pin;
         stable <= meta;
         prev   <= stable;
      end
   end

   assign edge_o.level = stable;
   assign edge_o.rise  = stable & ~prev;
   assign edge_o.fall  = ~stable & prev;
endmodule : tmv_pin_sync
`default_nettype wire

// file: core/tmv_timer.sv
// Eight-bit compare timer with AXI4-Lite register access
`default_nettype none
// Function
// - Eight-bit up-counter, readable and writable by software at any time.
// - Count clock source comes from the three-bit select field of control zero.
// - Wrap from all ones to zero sets the wrap flag.
// - Counter clears on reset and on low-power mode entry.
// - Compare A every cycle, skipped in the cycle compare A is written.
// - Match A sets its flag; interrupt raised when enabled.
// - Compare B behaves like compare A with its own flag and enable.
// - Both compare values load all ones on reset and low-power entry.
// - Control zero clears on reset and low-power entry.
// - Each interrupt gated by its enable bit seven, six or five.
// - Clear field: none, on match A, on match B.
// - With trigger gate on, clearing halts counting until a trigger edge.
// - With trigger gate off, counting continues right after a clear.
// - Wave output pin driven by compare matches per output select bits.
// - Flag bits cleared by writing zero, on reset and on low-power entry; software cannot set them.
// - External counter reset, count clock and start trigger inputs.
// - Extra select bit with the select field picks divide four to 128; external edge modes ignore it.
// - Clear field three clears on external reset rising edge.
// - Per-source keep, low, high, toggle; toggle beats high beats low.
// - Trigger edge field: off, rising, falling, both.
module tmv_timer
   import tmv_pkg::*;
(
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Low-power mode entry pulses
   input  wire logic          standby_entry,
   input  wire logic          sleep_mode_entry,
   // AXI4-Lite write
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output var  logic          s_axi_awready,
   input  wire logic [DW-1:0] s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output var  logic          s_axi_wready,
   output var  logic [1:0]    s_axi_bresp,
   output var  logic          s_axi_bvalid,
   input  wire logic          s_axi_bready,
   // AXI4-Lite read
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output var  logic          s_axi_arready,
   output var  logic [DW-1:0] s_axi_rdata,
   output var  logic [1:0]    s_axi_rresp,
   output var  logic          s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Timer pins
   input  wire logic          ext_count_clock_pin,
   input  wire logic          ext_counter_reset_pin,
   input  wire logic          start_trigger_pin,
   output var  logic          wave_out_pin,
   // Interrupt requests
   output var  logic          match_a_irq,
   output var  logic          match_b_irq,
   output var  logic          wrap_irq
);
   tmv_edge_if clk_e ();
   tmv_edge_if rst_e ();
   tmv_edge_if trg_e ();

   logic [7:0]         control_zero;
   logic [7:0]         compare_value_a;
   logic [7:0]         compare_value_b;
   logic [7:0]         count_value;
   logic [3:0]         out_sel;
   logic [1:0]         trig_edge;
   logic               trigger_gate_en;
   logic               clk_sel_extra;
   logic               match_a_flag;
   logic               match_b_flag;
   logic               wrap_flag;
   tmv_run_t           run_state;
   logic [PRESC_W-1:0] presc;
   logic               eq_a_q;
   logic               eq_b_q;
   logic               aw_hold;
   logic               w_hold;
   logic [15:0]        aw_idx;
   logic [7:0]         w_byte;
   logic               w_lane0;
   logic [15:0]        rd_idx;

   logic               low_power;
   logic               wr_go;
   logic               wr_hit;
   logic               wr_ctrl0;
   logic               wr_status;
   logic               wr_cmp_a;
   logic               wr_cmp_b;
   logic               wr_count;
   logic               wr_ctrl1;
   logic [DW-1:0]      rd_word;
   logic               rd_hit;
   logic [PRESC_W-1:0] next_presc;
   logic               int_tick;
   logic               ext_tick;
   logic               tick;
   logic               eq_a;
   logic               eq_b;
   logic               match_a;
   logic               match_b;
   logic               clear_evt;
   logic               trig_evt;
   logic               inc;
   logic               wrap;
   logic [7:0]         next_count;
   logic               next_wave;
   logic [1:0]         clear_sel;
   logic [2:0]         clk_sel;
   logic [2:0]         div_bit;

   // Pin synchronisers
   tmv_pin_sync u_clk_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (ext_count_clock_pin),
      .edge_o  (clk_e)
   );
   tmv_pin_sync u_rst_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (ext_counter_reset_pin),
      .edge_o  (rst_e)
   );
   tmv_pin_sync u_trg_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (start_trigger_pin),
      .edge_o  (trg_e)
   );

   assign low_power = standby_entry | sleep_mode_entry;
   assign clear_sel = control_zero[4:3];
   assign clk_sel   = control_zero[2:0];

   // Register write strobes; only byte lane 0 carries register data
   assign wr_go     = aw_hold & w_hold & ~s_axi_bvalid;
   assign wr_hit    = (aw_idx >= IDX_CTRL0) && (aw_idx <= IDX_CTRL1);
   assign wr_ctrl0  = wr_go & w_lane0 & (aw_idx == IDX_CTRL0);
   assign wr_status = wr_go & w_lane0 & (aw_idx == IDX_STATUS);
   assign wr_cmp_a  = wr_go & w_lane0 & (aw_idx == IDX_CMP_A);
   assign wr_cmp_b  = wr_go & w_lane0 & (aw_idx == IDX_CMP_B);
   assign wr_count  = wr_go & w_lane0 & (aw_idx == IDX_COUNT);
   assign wr_ctrl1  = wr_go & w_lane0 & (aw_idx == IDX_CTRL1);

   // Read mux
   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      if (rd_idx == IDX_CTRL0) begin
         rd_word[7:0] = control_zero;
      end else if (rd_idx == IDX_STATUS) begin
         rd_word[7:0] = STATUS_FIX | {match_b_flag, match_a_flag, wrap_flag, 1'b0, out_sel};
      end else if (rd_idx == IDX_CMP_A) begin
         rd_word[7:0] = compare_value_a;
      end else if (rd_idx == IDX_CMP_B) begin
         rd_word[7:0] = compare_value_b;
      end else if (rd_idx == IDX_COUNT) begin
         rd_word[7:0] = count_value;
      end else if (rd_idx == IDX_CTRL1) begin
         rd_word[7:0] = CTRL1_FIX | {3'h0, trig_edge, trigger_gate_en, 1'b0, clk_sel_extra};
      end else begin
         rd_hit = 1'b0;
      end
   end
   assign rd_idx = s_axi_araddr[AW-1:2];

   // Write address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         aw_hold       <= 1'b0;
         aw_idx        <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_hold       <= 1'b1;
         aw_idx        <= s_axi_awaddr[AW-1:2];
      end else if (wr_go) begin
         aw_hold <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_hold       <= 1'b0;
         w_byte       <= '0;
         w_lane0      <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_hold       <= 1'b1;
         w_byte       <= s_axi_wdata[7:0];
         w_lane0      <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_hold <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel; data is sampled when the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Prescaler: a divided clock falls when its bit goes from one to zero
   assign next_presc = presc + 1'b1;
   assign div_bit    = {clk_sel[1:0], clk_sel_extra} - 3'h1;
   assign int_tick   = ~clk_sel[2] & (clk_sel[1:0] != 2'h0)
                       & presc[div_bit] & ~next_presc[div_bit];
   always_comb begin
      ext_tick = 1'b0;
      if (clk_sel == CKS_EXT_RISE) begin
         ext_tick = clk_e.rise;
      end else if (clk_sel == CKS_EXT_FALL) begin
         ext_tick = clk_e.fall;
      end else if (clk_sel == CKS_EXT_BOTH) begin
         ext_tick = clk_e.rise | clk_e.fall;
      end
   end
   assign tick = int_tick | ext_tick;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc <= '0;
      end else begin
         presc <= next_presc;
      end
   end

   // Compare; a match is counted once when equality begins
   assign eq_a    = (count_value == compare_value_a) & ~wr_cmp_a;
   assign eq_b    = (count_value == compare_value_b) & ~wr_cmp_b;
   assign match_a = eq_a & ~eq_a_q;
   assign match_b = eq_b & ~eq_b_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eq_a_q <= 1'b0;
         eq_b_q <= 1'b0;
      end else begin
         eq_a_q <= wr_cmp_a ? eq_a_q : eq_a;
         eq_b_q <= wr_cmp_b ? eq_b_q : eq_b;
      end
   end

   // Clear source select
   always_comb begin
      clear_evt = 1'b0;
      if (clear_sel == CLR_A) begin
         clear_evt = match_a;
      end else if (clear_sel == CLR_B) begin
         clear_evt = match_b;
      end else if (clear_sel == CLR_EXT) begin
         clear_evt = rst_e.rise;
      end
   end

   // Trigger edge select
   always_comb begin
      trig_evt = 1'b0;
      if (trig_edge == EDGE_RISE) begin
         trig_evt = trg_e.rise;
      end else if (trig_edge == EDGE_FALL) begin
         trig_evt = trg_e.fall;
      end else if (trig_edge == EDGE_BOTH) begin
         trig_evt = trg_e.rise | trg_e.fall;
      end
   end

   // Next count: software write, then clear, then increment
   assign inc = tick & (run_state == TMV_RUN);
   always_comb begin
      next_count = count_value;
      wrap       = 1'b0;
      if (wr_count) begin
         next_count = w_byte;
      end else if (clear_evt) begin
         next_count = COUNT_RST;
      end else if (inc) begin
         next_count = count_value + 8'h01;
         wrap       = (count_value == COUNT_MAX);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || low_power) begin
         count_value <= COUNT_RST;
      end else begin
         count_value <= next_count;
      end
   end

   // Halt on clear while trigger gate is on; resume on a trigger edge
   always_ff @(posedge aclk) begin
      if (!aresetn || low_power) begin
         run_state <= TMV_RUN;
      end else begin
         case (run_state)
            TMV_RUN: begin
               if (clear_evt && trigger_gate_en) begin
                  run_state <= TMV_HALT;
               end
            end
            TMV_HALT: begin
               if (trig_evt) begin
                  run_state <= TMV_RUN;
               end
            end
            default: run_state <= TMV_RUN;
         endcase
      end
   end

   // Control and compare registers
   always_ff @(posedge aclk) begin
      if (!aresetn || low_power) begin
         control_zero    <= CTRL0_RST;
         compare_value_a <= CMP_RST;
         compare_value_b <= CMP_RST;
         out_sel         <= OS_RST;
      end else begin
         if (wr_ctrl0) begin
            control_zero <= w_byte;
         end
         if (wr_cmp_a) begin
            compare_value_a <= w_byte;
         end
         if (wr_cmp_b) begin
            compare_value_b <= w_byte;
         end
         if (wr_status) begin
            out_sel <= w_byte[3:0];
         end
      end
   end

   // Control one is left alone on standby entry
   always_ff @(posedge aclk) begin
      if (!aresetn || sleep_mode_entry) begin
         trig_edge       <= EDGE_RST;
         trigger_gate_en <= 1'b0;
         clk_sel_extra   <= 1'b0;
      end else if (wr_ctrl1) begin
         trig_edge       <= w_byte[4:3];
         trigger_gate_en <= w_byte[BIT_TRIGGER_GATE_EN];
         clk_sel_extra   <= w_byte[BIT_ICKS];
      end
   end

   // Flags: a zero write clears, a one write is ignored, a new event wins
   always_ff @(posedge aclk) begin
      if (!aresetn || low_power) begin
         match_a_flag <= 1'b0;
         match_b_flag <= 1'b0;
         wrap_flag    <= 1'b0;
      end else begin
         match_a_flag <= match_a
                         | (match_a_flag & ~(wr_status & ~w_byte[BIT_FLAG_A]));
         match_b_flag <= match_b
                         | (match_b_flag & ~(wr_status & ~w_byte[BIT_FLAG_B]));
         wrap_flag    <= wrap
                         | (wrap_flag & ~(wr_status & ~w_byte[BIT_FLAG_W]));
      end
   end

   // Interrupt requests follow the flags one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_a_irq <= 1'b0;
         match_b_irq <= 1'b0;
         wrap_irq    <= 1'b0;
      end else begin
         match_a_irq <= match_a_flag & control_zero[BIT_IRQ_A];
         match_b_irq <= match_b_flag & control_zero[BIT_IRQ_B];
         wrap_irq    <= wrap_flag & control_zero[BIT_IRQ_W];
      end
   end

   // Wave output: toggle beats high beats low across both sources
   always_comb begin
      next_wave = wave_out_pin;
      if ((match_a && out_sel[1:0] == OS_TOG) || (match_b && out_sel[3:2] == OS_TOG)) begin
         next_wave = ~wave_out_pin;
      end else if ((match_a && out_sel[1:0] == OS_HIGH)
                   || (match_b && out_sel[3:2] == OS_HIGH)) begin
         next_wave = 1'b1;
      end else if ((match_a && out_sel[1:0] == OS_LOW)
                   || (match_b && out_sel[3:2] == OS_LOW)) begin
         next_wave = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || low_power) begin
         wave_out_pin <= 1'b0;
      end else begin
         wave_out_pin <= next_wave;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_count_write_wins: assert property (
      wr_count && tick && !low_power |=> count_value == $past(w_byte))
      else $error("count write lost to increment");
   a_wrap_sets_flag: assert property (
      inc && !wr_count && !clear_evt && !low_power && count_value == COUNT_MAX
      |=> wrap_flag && count_value == COUNT_RST)
      else $error("wrap did not set flag");
   a_lowpower_count: assert property (
      low_power |=> count_value == COUNT_RST && run_state == TMV_RUN)
      else $error("count not cleared on low power");
   a_lowpower_regs: assert property (
      low_power |=> compare_value_a == CMP_RST && compare_value_b == CMP_RST
                    && control_zero == CTRL0_RST)
      else $error("registers not reinitialised");
   a_match_a_flag: assert property (
      count_value == compare_value_a && !wr_cmp_a && !eq_a_q && !low_power
      |=> match_a_flag)
      else $error("match A flag not set");
   a_match_b_flag: assert property (
      match_b && !low_power
      |=> match_b_flag ##1 (match_b_flag || $past(wr_status) || $past(low_power)))
      else $error("match B flag not set");
   a_irq_needs_enable: assert property (
      $rose(match_a_irq) |-> $past(control_zero[BIT_IRQ_A]) && $past(match_a_flag))
      else $error("match A irq without enable");
   a_clear_on_match: assert property (
      clear_sel == CLR_A && match_a && !wr_count && !low_power |=> count_value == COUNT_RST)
      else $error("match A did not clear count");
   a_halt_holds: assert property (
      run_state == TMV_HALT && !trig_evt && !wr_count && !clear_evt && !low_power
      |=> count_value == $past(count_value) && run_state == TMV_HALT)
      else $error("halted counter moved");
   a_no_gate_runs: assert property (
      clear_evt && !trigger_gate_en && run_state == TMV_RUN |=> run_state == TMV_RUN)
      else $error("counter halted without trigger gate");
   a_flag_no_sw_set: assert property (
      !match_b && !match_b_flag && !low_power |=> !match_b_flag)
      else $error("match B flag set without a match");
   a_wave_toggle: assert property (
      match_a && out_sel[1:0] == OS_TOG && !low_power
      |=> wave_out_pin != $past(wave_out_pin))
      else $error("wave output did not toggle");
   a_axi_resp: assert property (
      wr_go |=> s_axi_bvalid && !aw_hold && !w_hold)
      else $error("write response missing");

   c_wrap: cover property (inc && count_value == COUNT_MAX);
   c_halt_resume: cover property (run_state == TMV_HALT ##[1:50] run_state == TMV_RUN);
   c_both_match: cover property (match_a && match_b);
   c_ext_clear: cover property (clear_sel == CLR_EXT && rst_e.rise);
endmodule : tmv_timer
`default_nettype wire

// file: tb/tmv_pin_model.sv
// Board-side driver for the timer's count clock, counter reset and trigger pins
`default_nettype none
module tmv_pin_model (
   // Clock
   input  wire logic aclk,
   // Pins
   output var  logic ext_count_clock_pin,
   output var  logic ext_counter_reset_pin,
   output var  logic start_trigger_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ext_count_clock_pin   = 1'b0;
      ext_counter_reset_pin = 1'b0;
      start_trigger_pin     = 1'b0;
   end
   // Each level lasts at least 4 cycles so the pin synchroniser never misses an edge
   task automatic pulse_clock(input int n);
      repeat (n) begin
         @(posedge aclk) ext_count_clock_pin <= 1'b1;
         repeat (4) @(posedge aclk);
         ext_count_clock_pin <= 1'b0;
         repeat (4) @(posedge aclk);
      end
   endtask : pulse_clock
   task automatic set_trigger(input logic v);
      @(posedge aclk) start_trigger_pin <= v;
      repeat (4) @(posedge aclk);
   endtask : set_trigger
   task automatic pulse_reset();
      @(posedge aclk) ext_counter_reset_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_counter_reset_pin <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : pulse_reset
endmodule : tmv_pin_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the compare timer
`default_nettype none
module tb_top
   import tmv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [15:0] idx; logic [7:0] val; logic [1:0] resp;} tmv_row_t;
   logic          aclk, aresetn, standby_entry, sleep_mode_entry;
   logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DW-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]    s_axi_wstrb;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic          s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic          ext_count_clock_pin, ext_counter_reset_pin, start_trigger_pin;
   logic          wave_out_pin, match_a_irq, match_b_irq, wrap_irq;
   int            n_mismatch = 0;
   int            n_checks = 0;
   // Reset values; the unmapped row sits before control one, which standby keeps
   tmv_row_t rows[7] = '{'{IDX_CTRL0, CTRL0_RST, RESP_OKAY}, '{IDX_STATUS, STATUS_FIX, RESP_OKAY},
      '{IDX_CMP_A, CMP_RST, RESP_OKAY}, '{IDX_CMP_B, CMP_RST, RESP_OKAY},
      '{IDX_COUNT, COUNT_RST, RESP_OKAY}, '{16'hFFBE, 8'h00, RESP_SLVERR},
      '{IDX_CTRL1, CTRL1_FIX, RESP_OKAY}};
   tmv_timer tmv_timer_i (.aclk, .aresetn, .standby_entry, .sleep_mode_entry,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ext_count_clock_pin, .ext_counter_reset_pin,
      .start_trigger_pin, .wave_out_pin, .match_a_irq, .match_b_irq, .wrap_irq);
   tmv_pin_model tmv_pin_model_i (.aclk, .ext_count_clock_pin, .ext_counter_reset_pin,
      .start_trigger_pin);
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      fork
         begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
         begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
      join
      // Ready is raised only now so it never toggles twice in one step
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      check(s_axi_rdata, {24'h0, e});
      check(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
   endtask : rd_chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      {aresetn, standby_entry, sleep_mode_entry, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'h1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) rd_chk(rows[i].idx, rows[i].val, rows[i].resp);
      // Run through the wrap; both compares at all ones match on the way
      // Writes land three cycles apart, so one meets a divide-by-four tick
      wr(IDX_CTRL0, 8'h21);
      repeat (4) wr(IDX_COUNT, 8'hFE);
      repeat (20) @(posedge aclk);
      wr(IDX_CTRL0, 8'h20);
      rd_chk(IDX_STATUS, 8'hF0, RESP_OKAY);
      check({match_b_irq, match_a_irq, wrap_irq}, 3'b001);
      wr(IDX_STATUS, 8'h10);
      wr(IDX_STATUS, 8'hE0);
      rd_chk(IDX_STATUS, 8'h10, RESP_OKAY);
      check(wrap_irq, 1'b0);
      // Clear on match A with the trigger gate: counter halts at zero
      wr(IDX_COUNT, 8'h00);
      wr(IDX_CMP_A, 8'h05);
      wr(IDX_STATUS, 8'h03);
      wr(IDX_CTRL1, 8'h0C);
      rd_chk(IDX_CTRL1, 8'hEE, RESP_OKAY);
      wr(IDX_CTRL0, 8'h4D);
      tmv_pin_model_i.pulse_clock(7);
      rd_chk(IDX_COUNT, 8'h00, RESP_OKAY);
      rd_chk(IDX_STATUS, 8'h53, RESP_OKAY);
      check({match_a_irq, wave_out_pin}, 2'b11);
      tmv_pin_model_i.set_trigger(1'b1);
      tmv_pin_model_i.pulse_clock(2);
      rd_chk(IDX_COUNT, 8'h02, RESP_OKAY);
      // Gate off: the count carries on past the clear and the pin toggles back
      wr(IDX_CTRL1, 8'h00);
      tmv_pin_model_i.pulse_clock(5);
      rd_chk(IDX_COUNT, 8'h02, RESP_OKAY);
      check(wave_out_pin, 1'b0);
      // External counter reset clears the count from two
      wr(IDX_CTRL0, 8'h1D);
      tmv_pin_model_i.pulse_reset();
      rd_chk(IDX_COUNT, 8'h00, RESP_OKAY);
      wr(IDX_CTRL1, 8'h18);
      @(posedge aclk) standby_entry <= 1'b1;
      @(posedge aclk) standby_entry <= 1'b0;
      for (int i = 0; i < 6; i++) rd_chk(rows[i].idx, rows[i].val, rows[i].resp);
      rd_chk(IDX_CTRL1, 8'hFA, RESP_OKAY);
      @(posedge aclk) sleep_mode_entry <= 1'b1;
      @(posedge aclk) sleep_mode_entry <= 1'b0;
      foreach (rows[i]) rd_chk(rows[i].idx, rows[i].val, rows[i].resp);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
